// ### hdl/tcc_channel0.sv
// Channel-0 capture/compare unit with its 16-bit counter and register port.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tcc_channel0
  import tcc_pkg::*;
#(
  parameter int DW = TCC_DW
)
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire tcc_bus_req_t bus_i,
  output logic [DW-1:0] rdata_o,
  input wire logic capture_input_pin0_i,
  output logic timer_output_pin0_o,
  output logic channel0_match_irq_o,
  output logic counter_overflow_irq_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [DW-1:0] capture_compare_channel0;
  logic [DW-1:0] channel0_shadow;
  logic [DW-1:0] count;
  logic timer_count_enable;
  logic channel0_role_select;
  logic counter_overflow_flag;
  logic [2:0] mode;
  logic out_enable;
  logic [1:0] edge_sel;
  logic count_en_d;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  function automatic logic hit(input tcc_bus_req_t b, input logic [3:0] a);
    return b.addr == a;
  endfunction

  wire logic wr_ccr = bus_i.wr & hit(bus_i, TCC_ADDR_CAPCMP);
  wire logic wr_ctl0 = bus_i.wr & hit(bus_i, TCC_ADDR_CTL0);
  wire logic wr_opt0 = bus_i.wr & hit(bus_i, TCC_ADDR_OPT0);
  wire logic wr_ctl1 = bus_i.wr & hit(bus_i, TCC_ADDR_CTL1);

  wire tcc_role_t role =
    (mode == TCC_MODE_PULSE_WIDTH) ? TCC_ROLE_CAPTURE :
    ((mode == TCC_MODE_FREE_RUN) && channel0_role_select) ? TCC_ROLE_CAPTURE :
    TCC_ROLE_COMPARE;

  wire logic is_capture = (role == TCC_ROLE_CAPTURE);
  wire logic is_cycle = (mode != TCC_MODE_FREE_RUN) && (mode != TCC_MODE_PULSE_WIDTH);
  wire logic running = timer_count_enable & clk_en_i;
  wire logic capture_edge;
  wire logic match = running && !is_capture && (count == channel0_shadow);
  wire logic cap_fire = running && is_capture && capture_edge;
  wire logic clear_cnt = (match && is_cycle) ||
                         (cap_fire && (mode == TCC_MODE_PULSE_WIDTH));
  wire logic wrap = running && (mode == TCC_MODE_FREE_RUN) && (count == TCC_CNT_MAX);
  wire logic start = timer_count_enable & ~count_en_d;

  wire logic [DW-1:0] next_count = start ? TCC_CNT_RST :
                                   clear_cnt ? TCC_CNT_RST : count + 1'b1;

  // Overflow: hardware set beats a software clear in the same cycle.
  wire logic ovf_clr = wr_opt0 & ~bus_i.wdata[TCC_OPT0_OVF_BIT];
  wire logic next_ovf = wrap | (counter_overflow_flag & ~ovf_clr);

  wire logic [DW-1:0] opt0_view = {{(DW-8){1'b0}}, 3'h0, channel0_role_select,
                                   3'h0, counter_overflow_flag};
  wire logic [DW-1:0] ctl0_view = {{(DW-8){1'b0}}, timer_count_enable, 7'h00};
  wire logic [DW-1:0] ctl1_view = {{(DW-7){1'b0}}, edge_sel, out_enable, 1'b0, mode};
  // The register read sees the value as it stands at the strobe; a capture in
  // that same cycle lands one edge later, so the word is never torn.
  wire logic [DW-1:0] rd_mux =
    hit(bus_i, TCC_ADDR_CAPCMP) ? capture_compare_channel0 :
    hit(bus_i, TCC_ADDR_CTL0) ? ctl0_view :
    hit(bus_i, TCC_ADDR_OPT0) ? opt0_view :
    hit(bus_i, TCC_ADDR_CTL1) ? ctl1_view :
    hit(bus_i, TCC_ADDR_CNT) ? count : TCC_RD_ZERO;

  // ==========================================================================
  // Capture input
  // ==========================================================================
  tcc_edge_detect u_edge (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(clk_en_i),
    .pin_i(capture_input_pin0_i),
    .edge_sel_i(edge_sel),
    .edge_o(capture_edge)
  );

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_compare_channel0 <= TCC_CAPCMP_RST;
      channel0_shadow <= TCC_CAPCMP_RST;
    end else if (clk_en_i) begin
      if (cap_fire) begin
        capture_compare_channel0 <= count;
      end else if (wr_ccr) begin
        capture_compare_channel0 <= bus_i.wdata;
      end
      if (wr_ccr && !is_capture) begin
        channel0_shadow <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_count_enable <= 1'b0;
      channel0_role_select <= 1'b0;
      mode <= TCC_MODE_RST;
      out_enable <= 1'b0;
      edge_sel <= TCC_EDGE_RST;
      count_en_d <= 1'b0;
    end else if (clk_en_i) begin
      count_en_d <= timer_count_enable;
      if (wr_ctl0) begin
        timer_count_enable <= bus_i.wdata[TCC_CTL0_CE_BIT];
      end
      // Role select is taken as written; software keeps it steady while running.
      if (wr_opt0) begin
        channel0_role_select <= bus_i.wdata[TCC_OPT0_CCS0_BIT];
      end
      if (wr_ctl1) begin
        mode <= bus_i.wdata[TCC_CTL1_MODE_LSB +: 3];
        out_enable <= bus_i.wdata[TCC_CTL1_OE_BIT];
        edge_sel <= bus_i.wdata[TCC_CTL1_EDGE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= TCC_CNT_RST;
      counter_overflow_flag <= 1'b0;
      timer_output_pin0_o <= 1'b0;
      channel0_match_irq_o <= 1'b0;
      counter_overflow_irq_o <= 1'b0;
      rdata_o <= TCC_RD_ZERO;
    end else if (clk_en_i) begin
      if (running) begin
        count <= next_count;
      end else begin
        count <= TCC_CNT_RST;
      end
      counter_overflow_flag <= next_ovf;
      counter_overflow_irq_o <= wrap;
      channel0_match_irq_o <= match;
      if (match && out_enable) begin
        timer_output_pin0_o <= ~timer_output_pin0_o;
      end
      rdata_o <= bus_i.rd ? rd_mux : TCC_RD_ZERO;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  property p_cap_store;
    cap_fire |=> capture_compare_channel0 == $past(count);
  endproperty
  a_cap_store: assert property (p_cap_store) else $error("capture lost");

  property p_pw_clear;
    (cap_fire && mode == TCC_MODE_PULSE_WIDTH) |=> count == TCC_CNT_RST;
  endproperty
  a_pw_clear: assert property (p_pw_clear) else $error("pw not cleared");

  property p_pw_capture_only;
    (clk_en_i && mode == TCC_MODE_PULSE_WIDTH) |-> !match;
  endproperty
  a_pw_capture_only: assert property (p_pw_capture_only) else $error("pw compared");

  property p_other_compare;
    (clk_en_i && is_cycle) |-> !cap_fire;
  endproperty
  a_other_compare: assert property (p_other_compare) else $error("bad capture");

  property p_free_role;
    (mode == TCC_MODE_FREE_RUN) |-> (is_capture == channel0_role_select);
  endproperty
  a_free_role: assert property (p_free_role) else $error("role wrong");

  property p_match_irq;
    match |=> channel0_match_irq_o;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("irq missing");

  // The request is a single-cycle pulse unless the next count matches too.
  property p_irq_pulse;
    (clk_en_i && channel0_match_irq_o && !match) |=> !channel0_match_irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");

  property p_toggle;
    (clk_en_i && match && out_enable) |=> timer_output_pin0_o != $past(timer_output_pin0_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin not toggled");

  property p_cycle_clear;
    (clk_en_i && match && is_cycle) |=> count == TCC_CNT_RST;
  endproperty
  a_cycle_clear: assert property (p_cycle_clear) else $error("cycle not cleared");

  property p_shadow;
    (clk_en_i && wr_ccr && !is_capture) |=> channel0_shadow == $past(bus_i.wdata);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow stale");

  property p_ovf_set;
    (clk_en_i && wrap) |=> counter_overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow lost");

  property p_ovf_irq;
    (clk_en_i && wrap) |=> counter_overflow_irq_o;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

  property p_ovf_clear;
    (clk_en_i && ovf_clr && !wrap) |=> !counter_overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

  property p_ovf_keep;
    (clk_en_i && wr_opt0 && bus_i.wdata[TCC_OPT0_OVF_BIT] && counter_overflow_flag) |=>
      counter_overflow_flag;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow dropped");

  property p_wr_word;
    (clk_en_i && wr_ccr && !cap_fire) |=> capture_compare_channel0 == $past(bus_i.wdata);
  endproperty
  a_wr_word: assert property (p_wr_word) else $error("write lost");

  property p_cap_hold;
    (clk_en_i && !cap_fire && !wr_ccr) |=> $stable(capture_compare_channel0);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("register moved");

  // A read in a capture cycle returns the word as it stood before the capture.
  property p_rd_whole;
    (clk_en_i && bus_i.rd && hit(bus_i, TCC_ADDR_CAPCMP)) |=>
      rdata_o == $past(capture_compare_channel0);
  endproperty
  a_rd_whole: assert property (p_rd_whole) else $error("read torn");

  property p_shadow_hold;
    (clk_en_i && is_capture) |=> $stable(channel0_shadow);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved");

  property p_no_toggle;
    (clk_en_i && !(match && out_enable)) |=> $stable(timer_output_pin0_o);
  endproperty
  a_no_toggle: assert property (p_no_toggle) else $error("pin toggled");

  property p_free_count;
    (match && !is_cycle && !start && count != TCC_CNT_MAX) |=> count != TCC_CNT_RST;
  endproperty
  a_free_count: assert property (p_free_count) else $error("free count cleared");

  property p_edge_ignored;
    (clk_en_i && mode == TCC_MODE_FREE_RUN && !channel0_role_select && capture_edge && !wr_ccr)
      |=> $stable(capture_compare_channel0);
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("edge stored");

  // ==========================================================================
  // Cover points
  // ==========================================================================
  c_match: cover property (match && out_enable);
  c_cap: cover property (cap_fire);
  c_wrap: cover property (wrap);
  c_rd_cap: cover property (cap_fire && bus_i.rd);
  c_pw_clear: cover property (cap_fire && mode == TCC_MODE_PULSE_WIDTH);

endmodule // tcc_channel0

`default_nettype wire

// ### hdl/tcc_pkg.sv
// Package of constants and types for the channel-0 capture/compare block.
package tcc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0] TCC_ADDR_CAPCMP = 4'h0;
  localparam logic [3:0] TCC_ADDR_CTL0 = 4'h1;
  localparam logic [3:0] TCC_ADDR_OPT0 = 4'h2;
  localparam logic [3:0] TCC_ADDR_CTL1 = 4'h3;
  localparam logic [3:0] TCC_ADDR_CNT = 4'h4;
  localparam int TCC_AW = 4;
  localparam int TCC_DW = 16;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TCC_CTL0_CE_BIT = 7;
  localparam int TCC_OPT0_CCS0_BIT = 4;
  localparam int TCC_OPT0_OVF_BIT = 0;
  localparam int TCC_CTL1_MODE_LSB = 0;
  localparam int TCC_CTL1_OE_BIT = 4;
  localparam int TCC_CTL1_EDGE_LSB = 5;

  // ==========================================================================
  // Reset values and counter maximum
  // ==========================================================================
  localparam logic [15:0] TCC_CAPCMP_RST = 16'h0000;
  localparam logic [15:0] TCC_CNT_RST = 16'h0000;
  localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
  localparam logic [2:0] TCC_MODE_RST = 3'h0;
  localparam logic [1:0] TCC_EDGE_RST = 2'h0;
  localparam logic [15:0] TCC_RD_ZERO = 16'h0000;

  // ==========================================================================
  // Modes and edges
  // ==========================================================================
  localparam logic [2:0] TCC_MODE_INTERVAL = 3'h0;
  localparam logic [2:0] TCC_MODE_EXT_EVENT = 3'h1;
  localparam logic [2:0] TCC_MODE_EXT_TRIG = 3'h2;
  localparam logic [2:0] TCC_MODE_ONE_SHOT = 3'h3;
  localparam logic [2:0] TCC_MODE_PWM = 3'h4;
  localparam logic [2:0] TCC_MODE_FREE_RUN = 3'h5;
  localparam logic [2:0] TCC_MODE_PULSE_WIDTH = 3'h6;
  localparam logic [2:0] TCC_MODE_TRI_PWM = 3'h7;
  localparam logic [1:0] TCC_EDGE_NONE = 2'h0;
  localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCC_EDGE_FALL = 2'h2;
  localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    TCC_ROLE_COMPARE,
    TCC_ROLE_CAPTURE
  } tcc_role_t;

  // ==========================================================================
  // Bus carrier
  // ==========================================================================
  typedef struct packed {
    logic [TCC_AW-1:0] addr;
    logic [TCC_DW-1:0] wdata;
    logic wr;
    logic rd;
  } tcc_bus_req_t;

endpackage

// ### hdl/tcc_edge_detect.sv
// Pin synchroniser and selectable valid-edge detector for the capture input.
`timescale 1ns/1ps
`default_nettype none

module tcc_edge_detect
  import tcc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  output logic edge_o
);

  // ==========================================================================
  // Two-stage synchroniser and history
  // ==========================================================================
  logic sync1;
  logic sync2;
  logic prev;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else if (ce_i) begin
      sync1 <= pin_i;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  wire logic rise = sync2 & ~prev;
  wire logic fall = ~sync2 & prev;

  assign edge_o = ce_i & (((edge_sel_i == TCC_EDGE_RISE) & rise) |
                          ((edge_sel_i == TCC_EDGE_FALL) & fall) |
                          ((edge_sel_i == TCC_EDGE_BOTH) & (rise | fall)));

endmodule // tcc_edge_detect

`default_nettype wire

// ### tb/tcc_cpu_model.sv
// Model of the processor that reaches the channel-0 registers over the register port.
`timescale 1ns/1ps
`default_nettype none

module tcc_cpu_model
  import tcc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [15:0] rdata_i,
  output var tcc_bus_req_t bus_o
);
  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  // The processor only runs from the main clock here, so every access is allowed.
  initial begin
    bus_o = '0;
  end

  // One-cycle write strobe with a whole 16-bit word.
  task automatic bus_write(input logic [3:0] addr, input logic [15:0] data);
    @(posedge mclk_i);
    bus_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_o <= '{addr: addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic bus_read(input logic [3:0] addr, output logic [15:0] data);
    @(posedge mclk_i);
    bus_o <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_o <= '{addr: ~addr, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
    #1;
    data = rdata_i;
  endtask
endmodule // tcc_cpu_model

`default_nettype wire

// ### tb/test_timer_capture_compare_channel0.sv
// Self-checking testbench of the channel-0 capture/compare block.
`timescale 1ns/1ps
`default_nettype none

module test_timer_capture_compare_channel0;
  import tcc_pkg::*;

  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pin = 1'b0;
  logic clk_en = 1'b1;
  tcc_bus_req_t bus;
  logic [15:0] rdata;
  logic out_pin;
  logic match_irq;
  logic ovf_irq;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  tcc_channel0 i_tcc_channel0 (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en), .bus_i(bus),
    .rdata_o(rdata), .capture_input_pin0_i(pin), .timer_output_pin0_o(out_pin),
    .channel0_match_irq_o(match_irq), .counter_overflow_irq_o(ovf_irq)
  );

  tcc_cpu_model i_tcc_cpu_model (.mclk_i(mclk_i), .rdata_i(rdata), .bus_o(bus));

  // ==========================================================================
  // Clock, timeout and helpers
  // ==========================================================================
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_tcc_cpu_model.bus_write(a, d);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    i_tcc_cpu_model.bus_read(a, d);
  endtask

  // Counts cycles up to the next match pulse, bounded.
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n = n + 1;
    end while (match_irq !== 1'b1 && n < 200);
  endtask

  // Rising edge, falling edge ten cycles later, twenty cycles in all.
  task automatic pin_pulse();
    @(posedge mclk_i);
    pin <= 1'b1;
    repeat (10) @(posedge mclk_i);
    pin <= 1'b0;
    repeat (10) @(posedge mclk_i);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset_and_rw();
    logic [15:0] v;
    rd(TCC_ADDR_CAPCMP, v);
    check(v, 16'h0000, "register reset value");
    @(posedge mclk_i);
    #1;
    check(rdata, 16'h0000, "read data dropped after one cycle");
    rd(4'hf, v);
    check(v, 16'h0000, "unmapped read");
    wr(TCC_ADDR_CAPCMP, 16'ha5c3);
    rd(TCC_ADDR_CAPCMP, v);
    check(v, 16'ha5c3, "register write read");
  endtask

  task automatic t_interval();
    int n;
    logic p0;
    wr(TCC_ADDR_CTL1, 16'h0010);
    wr(TCC_ADDR_CAPCMP, 16'h0005);
    wr(TCC_ADDR_CTL0, 16'h0080);
    wait_irq(n);
    p0 = out_pin;
    wait_irq(n);
    check(n[15:0], 16'h0006, "cycle period");
    check({15'h0, out_pin}, {15'h0, ~p0}, "output toggle");
    wr(TCC_ADDR_CAPCMP, 16'h0009);
    wait_irq(n);
    wait_irq(n);
    wait_irq(n);
    check(n[15:0], 16'h000a, "period after running write");
    wr(TCC_ADDR_CTL0, 16'h0000);
  endtask

  task automatic t_compare_only_modes();
    logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [15:0] v;
    foreach (modes[i]) begin
      wr(TCC_ADDR_CTL1, {9'h0, 2'h3, 2'h0, modes[i]});
      wr(TCC_ADDR_CAPCMP, 16'h1234);
      wr(TCC_ADDR_CTL0, 16'h0080);
      pin_pulse();
      rd(TCC_ADDR_CAPCMP, v);
      check(v, 16'h1234, "no capture in compare mode");
      wr(TCC_ADDR_CTL0, 16'h0000);
    end
  endtask

  task automatic t_free_run();
    logic [15:0] a;
    logic [15:0] b;
    wr(TCC_ADDR_CTL1, 16'h0025);
    wr(TCC_ADDR_OPT0, 16'h0000);
    wr(TCC_ADDR_CAPCMP, 16'h4321);
    wr(TCC_ADDR_CTL0, 16'h0080);
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, a);
    check(a, 16'h4321, "compare role ignores edge");
    wr(TCC_ADDR_CTL0, 16'h0000);
    wr(TCC_ADDR_OPT0, 16'h0010);
    wr(TCC_ADDR_CTL0, 16'h0080);
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, a);
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, b);
    check(b - a, 16'h0017, "capture spacing");
    // Ten frozen cycles add eleven edges to the gap but only one count.
    @(posedge mclk_i);
    clk_en <= 1'b0;
    repeat (10) @(posedge mclk_i);
    clk_en <= 1'b1;
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, a);
    check(a - b, 16'h0018, "capture spacing across freeze");
    wr(TCC_ADDR_CTL0, 16'h0000);
  endtask

  task automatic t_pulse_width();
    logic [15:0] a;
    logic [15:0] b;
    wr(TCC_ADDR_CTL1, 16'h0026);
    wr(TCC_ADDR_CTL0, 16'h0080);
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, a);
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, a);
    pin_pulse();
    rd(TCC_ADDR_CAPCMP, b);
    check(b, a, "steady width capture");
    check({15'h0, (b >= 16'h0016 && b <= 16'h0017)}, 16'h0001, "width value");
    wr(TCC_ADDR_CTL0, 16'h0000);
  endtask

  task automatic t_overflow();
    logic [15:0] v;
    int n;
    wr(TCC_ADDR_CTL1, 16'h0005);
    wr(TCC_ADDR_OPT0, 16'h0000);
    wr(TCC_ADDR_CTL0, 16'h0080);
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n = n + 1;
    end while (ovf_irq !== 1'b1 && n < 66000);
    check({15'h0, ovf_irq}, 16'h0001, "overflow pulse");
    rd(TCC_ADDR_OPT0, v);
    check(v & 16'h0001, 16'h0001, "overflow flag set");
    wr(TCC_ADDR_OPT0, 16'h0001);
    rd(TCC_ADDR_OPT0, v);
    check(v & 16'h0001, 16'h0001, "writing one keeps flag");
    wr(TCC_ADDR_OPT0, 16'h0000);
    rd(TCC_ADDR_OPT0, v);
    check(v & 16'h0001, 16'h0000, "writing zero clears flag");
    wr(TCC_ADDR_CTL0, 16'h0000);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset_and_rw();
    t_interval();
    t_compare_only_modes();
    t_free_run();
    t_pulse_width();
    t_overflow();
    final_report();
  end
endmodule // test_timer_capture_compare_channel0

`default_nettype wire
